// *** design/fpep_top.v ***
// flash program/erase sequencer with block protection and wishbone register slave
//
// Operation
// RQ1 - erased reads one, programmed reads zero
// RQ2 - 7680 or 4096 bytes, vectors, protect
// RQ3 - page is 64 bytes, fully erased
// RQ4 - high voltage bit drives charge pump
// RQ5 - high voltage needs select plus sequence
// RQ6 - mass select erases entire array
// RQ7 - erase and program selects interlocked
// RQ8 - software page erase timing sequence
// RQ9 - software mass erase timing sequence
// RQ10 - software waits recovery before reading
// RQ11 - software runs outside array, keeps order
// RQ12 - monitor mass erase writes protect byte
// RQ13 - program rows of 32 aligned bytes
// RQ14 - program select latches address and data
// RQ15 - software row program timing sequence
// RQ16 - software keeps within max byte time
// RQ17 - protected target blocks high voltage
// RQ18 - zeros protect all, ones protect none
// RQ19 - protect byte locked without test voltage; code leaves it writable when the protect bits are all ones
// RQ20 - protect start from bits 13:6
// RQ21 - wait/stop aborts into standby
// RQ22 - wait/stop harmless while reading
// RQ23 - reset clears selects and high voltage
`include "fpep_consts.vh"
`default_nettype none
module fpep_top #(
    parameter        LARGE_VARIANT = 1,
    parameter [7:0]  PROT_INIT     = 8'hff
) (
    input  wire        CORE_CLK,
    input  wire        RESET_N,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [15:0] WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    input  wire        LOW_POWER_REQ,
    input  wire        TEST_HIGH_VOLTAGE,
    output reg         CHARGE_PUMP_ON,
    output reg         ARRAY_HV_ON
);
    localparam TRCV_CYC = (`FPEP_TRCV_NS + `FPEP_CLK_NS - 1) / `FPEP_CLK_NS;
    localparam [15:0] USER_BASE = LARGE_VARIANT ? `FPEP_BASE_LARGE : `FPEP_BASE_SMALL;
    localparam ST_IDLE   = 2'h0;
    localparam ST_READ   = 2'h1;
    localparam ST_ACK    = 2'h2;
    localparam ST_HOLD   = 2'h3;

    // control and sequencing state
    reg        program_select_q;
    reg        erase_select_q;
    reg        mass_select_q;
    reg        high_voltage_enable_q;
    reg        prot_read_q;
    reg        target_ok_q;
    reg        latched_q;
    reg [15:0] target_addr_q;
    reg        refused_q;
    reg        standby_q;
    reg [7:0]  protect_start_bits_q;
    reg        prot_loaded_q;
    reg [1:0]  bus_state_q;
    reg [15:0] rcv_cnt_q;
    reg        prog_pulse_q;
    reg [15:0] prog_addr_q;
    reg [7:0]  prog_data_q;
    reg        erase_pulse_q;
    reg        erase_mass_q;

    wire        access   = WB_CYC_I && WB_STB_I;
    wire        sel_low  = WB_SEL_I[0];
    wire        wr_ctrl  = access && WB_WE_I && sel_low && (WB_ADR_I == `FPEP_OFS_CTRL) && (bus_state_q == ST_IDLE);
    wire [7:0]  wdat     = WB_DAT_I[7:0];
    // register read strobes, idle state only
    wire        take     = access && (bus_state_q == ST_IDLE);
    wire        rd_prot  = take && !WB_WE_I && (WB_ADR_I == `FPEP_OFS_PROT);
    wire        rd_stat  = take && !WB_WE_I && (WB_ADR_I == `FPEP_OFS_STAT);
    wire        arr_rd_hit;
    wire [7:0]  arr_rd_data;
    wire [15:0] prot_start;

    // RQ2 user array, vectors and protect byte
    function in_array;
        input [15:0] a;
        begin
            in_array = ((a >= USER_BASE) && (a <= `FPEP_USER_TOP)) ||
                       (a >= `FPEP_VEC_BASE) || (a == `FPEP_OFS_PROT);
        end
    endfunction

    // RQ3 page base address
    function [15:0] page_base;
        input [15:0] a;
        begin
            page_base = a & `FPEP_PAGE_MASK;
        end
    endfunction

    // RQ13 row base address
    function [15:0] row_base;
        input [15:0] a;
        begin
            row_base = a & `FPEP_ROW_MASK;
        end
    endfunction

    // RQ17 address falls in protected range
    function is_protected;
        input [15:0] a;
        input [7:0]  bits;
        input [15:0] start;
        begin
            // RQ18 all ones open, zeros lock all
            if (bits == `FPEP_PROT_NONE)
                is_protected = 1'b0;
            else if (bits == `FPEP_PROT_ALL)
                is_protected = 1'b1;
            else
                is_protected = (a >= start) || (a == `FPEP_OFS_PROT);
        end
    endfunction

    // RQ20 start address from protect bits
    assign prot_start = {`FPEP_PROT_HI, protect_start_bits_q, `FPEP_PROT_LO};

    assign arr_rd_hit = in_array(WB_ADR_I);

    // RQ19 test voltage lifts protection
    wire tgt_blocked = is_protected(WB_ADR_I, protect_start_bits_q, prot_start) && !TEST_HIGH_VOLTAGE;
    wire arr_wr      = access && WB_WE_I && sel_low && arr_rd_hit && (bus_state_q == ST_IDLE);

    fpep_array #(
        .AW (13)
    ) u_array (
        .clk        (CORE_CLK),
        .rd_addr    (WB_ADR_I[12:0]),
        .rd_data    (arr_rd_data),
        .prog_en    (prog_pulse_q),
        .prog_addr  (prog_addr_q[12:0]),
        .prog_data  (prog_data_q),
        .erase_en   (erase_pulse_q),
        .erase_all  (erase_mass_q),
        .erase_addr (target_addr_q[12:0])
    );

    // protect byte shadow tracks the stored byte
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            protect_start_bits_q <= `FPEP_PROT_NONE;
            prot_loaded_q        <= 1'b0;
        end else if (!prot_loaded_q) begin
            protect_start_bits_q <= PROT_INIT;
            prot_loaded_q        <= 1'b1;
        end else if (erase_pulse_q && (erase_mass_q ||
                     (page_base(target_addr_q) == page_base(`FPEP_OFS_PROT)))) begin
            protect_start_bits_q <= `FPEP_PROT_NONE;
        end else if (prog_pulse_q && (prog_addr_q == `FPEP_OFS_PROT)) begin
            protect_start_bits_q <= protect_start_bits_q & prog_data_q;
        end
    end

    // control register and program/erase sequencing
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            // RQ23 reset leaves read mode
            program_select_q      <= 1'b0;
            erase_select_q        <= 1'b0;
            mass_select_q         <= 1'b0;
            high_voltage_enable_q <= 1'b0;
            prot_read_q           <= 1'b0;
            target_ok_q           <= 1'b0;
            latched_q             <= 1'b0;
            target_addr_q         <= 16'h0000;
            refused_q             <= 1'b0;
            standby_q             <= 1'b0;
            prog_pulse_q          <= 1'b0;
            prog_addr_q           <= 16'h0000;
            prog_data_q           <= 8'h00;
            erase_pulse_q         <= 1'b0;
            erase_mass_q          <= 1'b0;
        end else begin
            prog_pulse_q  <= 1'b0;
            erase_pulse_q <= 1'b0;
            if (LOW_POWER_REQ && (program_select_q || erase_select_q || high_voltage_enable_q)) begin
                // RQ21 abort into standby
                program_select_q      <= 1'b0;
                erase_select_q        <= 1'b0;
                mass_select_q         <= 1'b0;
                high_voltage_enable_q <= 1'b0;
                prot_read_q           <= 1'b0;
                latched_q             <= 1'b0;
                standby_q             <= 1'b1;
            end else if (wr_ctrl) begin
                standby_q <= 1'b0;
                mass_select_q <= wdat[`FPEP_BIT_MASS];
                // RQ7 selects interlocked
                if (wdat[`FPEP_BIT_PGM] && wdat[`FPEP_BIT_ERASE]) begin
                    refused_q <= 1'b1;
                end else begin
                    if (wdat[`FPEP_BIT_PGM] && !erase_select_q)
                        program_select_q <= 1'b1;
                    else if (!wdat[`FPEP_BIT_PGM])
                        program_select_q <= 1'b0;
                    if (wdat[`FPEP_BIT_ERASE] && !program_select_q)
                        erase_select_q <= 1'b1;
                    else if (!wdat[`FPEP_BIT_ERASE])
                        erase_select_q <= 1'b0;
                    if ((wdat[`FPEP_BIT_PGM] && erase_select_q) || (wdat[`FPEP_BIT_ERASE] && program_select_q))
                        refused_q <= 1'b1;
                end
                if (!wdat[`FPEP_BIT_PGM] && !wdat[`FPEP_BIT_ERASE] && !high_voltage_enable_q) begin
                    prot_read_q <= 1'b0;
                    latched_q   <= 1'b0;
                end
                // RQ5 high voltage only after sequence
                if (wdat[`FPEP_BIT_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable_q) begin
                    if ((program_select_q || erase_select_q) && prot_read_q && latched_q && target_ok_q)
                        high_voltage_enable_q <= 1'b1;
                    else
                        refused_q <= 1'b1;
                end else if (!wdat[`FPEP_BIT_HIGH_VOLTAGE_ENABLE]) begin
                    high_voltage_enable_q <= 1'b0;
                    if (high_voltage_enable_q) begin
                        prot_read_q <= 1'b0;
                        latched_q   <= 1'b0;
                    end
                end
            end else if (rd_prot) begin
                if (program_select_q || erase_select_q)
                    prot_read_q <= 1'b1;
            end else if (arr_wr) begin
                // RQ14 latch target address and protection result
                if ((program_select_q || erase_select_q) && prot_read_q && !high_voltage_enable_q) begin
                    latched_q     <= 1'b1;
                    target_addr_q <= erase_select_q ? page_base(WB_ADR_I) : row_base(WB_ADR_I);
                    // RQ17 protected target refuses high voltage
                    target_ok_q   <= erase_select_q && mass_select_q ?
                                     !(protect_start_bits_q != `FPEP_PROT_NONE && !TEST_HIGH_VOLTAGE) :
                                     !tgt_blocked;
                end else if (program_select_q && high_voltage_enable_q) begin
                    // RQ13 bytes must stay in latched row
                    if (row_base(WB_ADR_I) == target_addr_q) begin
                        prog_pulse_q <= 1'b1;
                        prog_addr_q  <= WB_ADR_I;
                        prog_data_q  <= wdat;
                    end else begin
                        refused_q <= 1'b1;
                    end
                end
            end
            // RQ6 erase fires as select drops under high voltage
            // page or whole array chosen before the clearing write
            if (wr_ctrl && erase_select_q && high_voltage_enable_q && !wdat[`FPEP_BIT_ERASE] && !LOW_POWER_REQ) begin
                erase_pulse_q <= 1'b1;
                erase_mass_q  <= mass_select_q;
            end
            // status read clears the refused flag
            if (rd_stat)
                refused_q <= 1'b0;
        end
    end

    // RQ4 pump and array high voltage follow enable
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CHARGE_PUMP_ON <= 1'b0;
            ARRAY_HV_ON    <= 1'b0;
        end else begin
            CHARGE_PUMP_ON <= high_voltage_enable_q && !LOW_POWER_REQ;
            ARRAY_HV_ON    <= high_voltage_enable_q && !LOW_POWER_REQ;
        end
    end

    // recovery counter after high voltage drops
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N)
            rcv_cnt_q <= 16'h0000;
        else if (high_voltage_enable_q)
            rcv_cnt_q <= TRCV_CYC[15:0];
        else if (rcv_cnt_q != 16'h0000)
            rcv_cnt_q <= rcv_cnt_q - 16'h0001;
    end

    // wishbone slave: idle, read wait, ack, hold
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_state_q <= ST_IDLE;
            WB_ACK_O    <= 1'b0;
            WB_DAT_O    <= 32'h00000000;
        end else begin
            case (bus_state_q)
                ST_IDLE: begin
                    WB_ACK_O <= 1'b0;
                    if (access) begin
                        if (!WB_WE_I && arr_rd_hit && WB_ADR_I != `FPEP_OFS_PROT) begin
                            bus_state_q <= ST_READ;
                        end else begin
                            bus_state_q <= ST_ACK;
                            WB_ACK_O    <= 1'b1;
                            if (WB_WE_I)
                                WB_DAT_O <= 32'h00000000;
                            else if (WB_ADR_I == `FPEP_OFS_CTRL)
                                WB_DAT_O <= {28'h0000000, high_voltage_enable_q, mass_select_q,
                                             erase_select_q, program_select_q};
                            else if (WB_ADR_I == `FPEP_OFS_PROT)
                                WB_DAT_O <= {24'h000000, protect_start_bits_q};
                            else if (WB_ADR_I == `FPEP_OFS_STAT)
                                WB_DAT_O <= {28'h0000000, standby_q, refused_q,
                                             protect_start_bits_q != `FPEP_PROT_NONE,
                                             high_voltage_enable_q || rcv_cnt_q != 16'h0000};
                            else
                                WB_DAT_O <= 32'h00000000;
                        end
                    end
                end
                ST_READ: begin
                    // RQ22 reads unaffected by low power
                    WB_ACK_O    <= 1'b1;
                    WB_DAT_O    <= {24'h000000, arr_rd_data};
                    bus_state_q <= ST_ACK;
                end
                ST_ACK: begin
                    WB_ACK_O    <= 1'b0;
                    bus_state_q <= ST_HOLD;
                end
                ST_HOLD: begin
                    WB_ACK_O <= 1'b0;
                    if (!access)
                        bus_state_q <= ST_IDLE;
                end
                default: begin
                    WB_ACK_O    <= 1'b0;
                    bus_state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** inc/fpep_consts.vh ***
// constants for the flash program/erase/protect sequencer
`ifndef FPEP_CONSTS_VH
`define FPEP_CONSTS_VH

// register byte offsets on the wishbone bus
`define FPEP_OFS_CTRL        16'hfe08
`define FPEP_OFS_PROT        16'hff7e
`define FPEP_OFS_STAT        16'hfe0c

// control register bit positions
`define FPEP_BIT_PGM         0
`define FPEP_BIT_ERASE       1
`define FPEP_BIT_MASS        2
`define FPEP_BIT_HIGH_VOLTAGE_ENABLE        3

// status register bit positions
`define FPEP_ST_ARMED        0
`define FPEP_ST_PROTD        1
`define FPEP_ST_REFUSED      2
`define FPEP_ST_STANDBY      3

// array geometry
`define FPEP_BASE_LARGE      16'he000
`define FPEP_BASE_SMALL      16'hee00
`define FPEP_USER_TOP        16'hfdff
`define FPEP_VEC_BASE        16'hffdc
`define FPEP_ARRAY_TOP       16'hffff
`define FPEP_PAGE_MASK       16'hffc0
`define FPEP_ROW_MASK        16'hffe0
`define FPEP_PROT_HI         2'h3
`define FPEP_PROT_LO         6'h00
`define FPEP_PROT_ALL        8'h00
`define FPEP_PROT_NONE       8'hff
`define FPEP_ERASED_BYTE     8'hff

// timing, in nanoseconds, and the clock period
`define FPEP_CLK_NS          20
`define FPEP_TRCV_NS         1000

`endif

// *** design/fpep_array.v ***
// byte-wide flash array model with registered read, byte program and page/mass erase
`default_nettype none
module fpep_array #(
    parameter AW = 13
) (
    input  wire          clk,
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]    rd_data,
    input  wire          prog_en,
    input  wire [AW-1:0] prog_addr,
    input  wire [7:0]    prog_data,
    input  wire          erase_en,
    input  wire          erase_all,
    input  wire [AW-1:0] erase_addr
);
    localparam DEPTH = 1 << AW;
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    always @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

    // RQ1 erase to ones, program clears bits
    always @(posedge clk) begin
        if (erase_en) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                // RQ3 whole page erased
                if (erase_all || ((i >> 6) == (erase_addr >> 6)))
                    mem[i] <= `FPEP_ERASED_BYTE;
            end
        end else if (prog_en) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
    end
endmodule
`default_nettype wire

// *** dv/fpep_top_properties.sv ***
// port-level assertions for the flash sequencer
`default_nettype none
module fpep_top_props #(
    parameter [7:0] PROT_INIT = 8'hff
) (
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        LOW_POWER_REQ,
    input wire logic        CHARGE_PUMP_ON,
    input wire logic        ARRAY_HV_ON
);
    timeunit 1ns;
    timeprecision 1ps;
    wire hv_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 16'hfe08 && WB_DAT_I[3];
    wire rd_ack = WB_ACK_O && !WB_WE_I;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    property p_reset_quiet;
        $rose(RESET_N) |-> !CHARGE_PUMP_ON && !ARRAY_HV_ON && !WB_ACK_O;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active right after reset");
    property p_pump_pair;
        CHARGE_PUMP_ON == ARRAY_HV_ON;
    endproperty
    a_pump_pair: assert property (p_pump_pair)
        else $error("pump and array high voltage disagree");
    property p_hv_cause;
        $rose(CHARGE_PUMP_ON) |-> $past(hv_wr, 2) || $past(hv_wr, 3);
    endproperty
    a_hv_cause: assert property (p_hv_cause)
        else $error("pump rose without a control write");
    property p_interlock;
        rd_ack && WB_ADR_I == 16'hfe08 |-> !(WB_DAT_O[0] && WB_DAT_O[1]);
    endproperty
    a_interlock: assert property (p_interlock)
        else $error("both selects read back set");
    property p_abort;
        LOW_POWER_REQ |-> ##[1:2] !CHARGE_PUMP_ON;
    endproperty
    a_abort: assert property (p_abort)
        else $error("pump still on after low power request");
    property p_prot_read;
        rd_ack && WB_ADR_I == 16'hff7e |-> WB_DAT_O[7:0] == PROT_INIT;
    endproperty
    a_prot_read: assert property (p_prot_read)
        else $error("protect register read wrong");
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_bound;
        $rose(WB_CYC_I && WB_STB_I) |-> ##[1:2] WB_ACK_O;
    endproperty
    a_ack_bound: assert property (p_ack_bound)
        else $error("ack late");
    property p_hi_zero;
        WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read data not zero");
    c_pump_on: cover property ($rose(CHARGE_PUMP_ON));
    c_abort: cover property (LOW_POWER_REQ && CHARGE_PUMP_ON);
    c_ctrl_read: cover property (rd_ack && WB_ADR_I == 16'hfe08);
endmodule
bind fpep_top fpep_top_props #(.PROT_INIT(PROT_INIT)) fpep_top_props_i (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .LOW_POWER_REQ(LOW_POWER_REQ), .CHARGE_PUMP_ON(CHARGE_PUMP_ON),
    .ARRAY_HV_ON(ARRAY_HV_ON)
);
`default_nettype wire

// *** dv/fpep_top_bench.sv ***
// self-checking bench for the flash sequencer
`default_nettype none
module fpep_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CTRL     = 16'hfe08;
    localparam logic [15:0] PROT     = 16'hff7e;
    localparam logic [15:0] STAT     = 16'hfe0c;
    localparam logic [7:0]  PROT_VAL = 8'hfe;
    logic        core_clk;
    logic        reset_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    wire  [31:0] dat_r;
    wire         ack;
    logic        low_power;
    logic        test_hv;
    wire         pump;
    wire         hv_on;
    int          errors;
    int          check_count;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [7:0]  d0;
    logic [7:0]  d1;

    fpep_top #(.PROT_INIT(PROT_VAL)) fpep_top_i (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .LOW_POWER_REQ(low_power), .TEST_HIGH_VOLTAGE(test_hv), .CHARGE_PUMP_ON(pump),
        .ARRAY_HV_ON(hv_on)
    );

    always #10 core_clk = ~core_clk;

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, input logic c, input logic [7:0] e);
        int n;
        exp_q.push_back({c, 24'h0, e});
        @(posedge core_clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'h1;
        dat_w <= {24'h0, d};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            errors++;
            $display("[FAIL] ack timeout expected 1 seen %b", ack);
            conclude();
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b1, e);
    endtask

    task automatic hv(input logic e);
        repeat (3) @(posedge core_clk);
        cmp("pump", {31'h0, e}, {31'h0, pump});
        cmp("array hv", {31'h0, e}, {31'h0, hv_on});
    endtask

    // select, protect read, target write, then high voltage
    // steps kept in order
    task automatic seq(input logic [7:0] s, input logic [15:0] a, input logic ok);
        wr(CTRL, s);
        rd(PROT, PROT_VAL);
        wr(a, 8'hff);
        wr(CTRL, s | 8'h08);
        rd(CTRL, ok ? (s | 8'h08) : s);
        hv(ok);
    endtask

    task automatic close;
        wr(CTRL, 8'h08);
        wr(CTRL, 8'h00);
        repeat (60) @(posedge core_clk);
    endtask

    // pop the oldest note on each answer, compare read data with it
    always @(posedge core_clk) begin
        if (ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("stray ack", 32'h0, 32'h1);
            end else begin
                note = exp_q.pop_front();
                if (note[32]) begin
                    cmp("read data", note[31:0], dat_r);
                end
            end
        end
    end

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0;
        sel = 4'h0;
        dat_w = 32'h0;
        low_power = 1'b0;
        test_hv = 1'b0;
        errors = 0;
        check_count = 0;
        void'($urandom(32'hc6156056));
        d0 = 8'($urandom());
        d1 = 8'($urandom());
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(CTRL, 8'h00);
        hv(1'b0);
        rd(16'h1234, 8'h00);
        wr(16'h1234, 8'h5a);
        wr(CTRL, 8'h03);
        rd(CTRL, 8'h00);
        rd(STAT, 8'h06);
        wr(CTRL, 8'h08);
        rd(CTRL, 8'h00);
        seq(8'h02, 16'he000, 1'b1);
        close();
        rd(16'he000, 8'hff);
        rd(16'he03f, 8'hff);
        seq(8'h01, 16'he000, 1'b1);
        wr(16'he000, d0);
        wr(16'he01f, d1);
        wr(16'he020, 8'h00);
        close();
        low_power <= 1'b1;
        rd(16'he000, d0);
        low_power <= 1'b0;
        rd(16'he01f, d1);
        rd(16'he020, 8'hff);
        seq(8'h02, 16'hffdc, 1'b0);
        close();
        seq(8'h06, 16'he000, 1'b0);
        close();
        seq(8'h02, 16'he040, 1'b1);
        low_power <= 1'b1;
        hv(1'b0);
        low_power <= 1'b0;
        rd(CTRL, 8'h00);
        rd(STAT, 8'h0f);
        test_hv <= 1'b1;
        seq(8'h06, 16'hff7e, 1'b1);
        close();
        rd(16'he000, 8'hff);
        rd(16'hfdff, 8'hff);
        repeat (2) @(posedge core_clk);
        conclude();
    end
endmodule
`default_nettype wire
